// *** include/drm_pkg.sv ***
// Shared constants and types of the drum integrator sequencer.
// Assumes one 250 MHz clock; drum pulses arrive far slower than it.
package drm_pkg;

	localparam int CLK_PERIOD_NS = 4;

	// Register byte offsets on APB.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SLOT = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_READOUT = 8'h0C;

	// Control register fields.
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_EREF_BIT = 3;
	localparam int CTRL_SRC_BIT = 4;
	localparam int CTRL_HALF_BIT = 5;

	// Status register fields.
	localparam int ST_SLOT_LSB = 5;
	localparam int ST_POS_LSB = 10;

	// Readout register fields.
	localparam int RO_OCT_LSB = 3;
	localparam int RO_INC_LSB = 6;

	// Counter sequences.
	localparam logic [4:0] POS_RELOAD = 5'h08;
	localparam logic [4:0] POS_FULL = 5'h1F;
	localparam logic [4:0] SLOT_RELOAD = 5'h0A;
	localparam logic [4:0] SLOT_FULL = 5'h1F;
	localparam logic [5:0] POS_FIRST = 6'h01;
	localparam logic [5:0] POS_WIN_OPEN = 6'h17;
	localparam logic [5:0] POS_WIN_CLOSE = 6'h2F;
	localparam logic [5:0] POS_LAST = 6'h30;
	localparam logic [4:0] SLOT_FIRST = 5'h01;
	localparam logic [4:0] SLOT_LAST = 5'h16;
	localparam logic [2:0] INC_MAX = 3'h7;

	// Reset values.
	localparam logic [4:0] SEL_SLOT_RST = 5'h01;
	localparam logic [2:0] OCT_RST = 3'h0;

	// Synchroniser lanes of the pin inputs.
	localparam int PIN_CLK = 0;
	localparam int PIN_R_POS = 1;
	localparam int PIN_R_NEG = 2;
	localparam int PIN_Y_POS = 3;
	localparam int PIN_Y_NEG = 4;
	localparam int PIN_Z_POS = 5;
	localparam int PIN_Z_NEG = 6;
	localparam int PIN_ONE = 7;
	localparam int PIN_ZERO = 8;
	localparam int PIN_N = 9;

	typedef enum logic [2:0] {
		MODE_FILL_Y,
		MODE_FILL_R,
		MODE_STEP_LEFT,
		MODE_STEP_RIGHT,
		MODE_ONE_OP,
		MODE_COMPUTE
	} drm_mode_t;

endpackage : drm_pkg

// *** logic/drm_sequencer.sv ***
// Control and sequencing of a serial drum-memory differential analyzer.
// Assumes drum head pulses and panel buttons are asynchronous pins and that
// the serial adders sit outside and share pclk.
// Function
// [R1] Run gate changes only at slot 22-to-1.
// [R2] Run gate ends after one turn, or halt.
// [R3] Button sets request; first pulse after clears.
// [R4] Halt holds overflow P48 I1 to P48 I22.
// [R5] Octal counter picks digit group and lamps.
// [R6] Slot counter: five stages, 10 to 32.
// [R7] Hold register shows each digit one revolution; at octal count 7 it is never loaded and keeps digit 6.
// [R8] Three-stage shifter gathers three bits.
// [R9] Input flip-flop resamples on clock channel.
// [R10] Tracking flip-flop rebuilds square wave from pulses.
// [R11] Integrand, overflow channels track like remainder.
// [R12] Parallel driver copies integrand input flip-flop.
// [R13] Adder window: integrand after P23 until P47.
// [R14] Window enables adder and increment add.
// [R15] One button sets fill value, zero clears.
// [R16] Fill and step-right record from input stage.
// [R17] Idle overflow line recirculates from first delay.
// [R18] Computing records from second delay stage.
// [R19] Overflow line carries fresh overflows each revolution.
// [R20] Position counter: 8 to 32, half toggles.
// [R21] Increment counter saturates at seven, clears P48.
// [R22] Fill/step-right precess 47, step-left 49.
// [R23] All sequencing advances on clock-channel pulses.
`timescale 1ns/1ps
`default_nettype none
module drm_sequencer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic drum_clock_pin,
	input wire logic rem_pos_pin,
	input wire logic rem_neg_pin,
	input wire logic intg_pos_pin,
	input wire logic intg_neg_pin,
	input wire logic ovf_pos_pin,
	input wire logic ovf_neg_pin,
	input wire logic one_button_pin,
	input wire logic zero_button_pin,
	input wire logic first_rem_overflow,
	input wire logic rem_overflow,
	input wire logic dy_pickup,
	output logic ovf_record_bit,
	output logic intg_record_en,
	output logic rem_record_en,
	output logic fill_record_bit,
	output logic adder_enable,
	output logic dy_add_request,
	output logic [2:0] increment_count,
	output logic [2:0] lamp_bank,
	output logic [2:0] lamp_digit,
	output logic integrand_sync,
	output logic integrand_sync_driver,
	output logic remainder_sync
);
	import drm_pkg::*;

	typedef struct packed {
		logic [PIN_N-1:0] s1;
		logic [PIN_N-1:0] s2;
		logic [PIN_N-1:0] s3;
		logic rem_track;
		logic intg_track;
		logic ovf_track;
		logic rem_sync;
		logic intg_sync;
		logic intg_drv;
		logic ovf_sync;
		logic ovf_delay1;
		logic ovf_delay2;
		logic ovf_rec;
		logic [4:0] pos_cnt;
		logic half;
		logic [4:0] slot_cnt;
		logic run_gate;
		logic run_request;
		logic halt_latch;
		logic adder_window;
		logic fill_value;
		logic [2:0] inc_cnt;
		logic stage1;
		logic stage2;
		logic load_due;
		logic [2:0] hold;
		logic [2:0] oct_sel;
		logic intg_wr;
		logic rem_wr;
		logic wr_bit;
		drm_mode_t mode;
		logic eref;
		logic ro_src;
		logic ro_half;
		logic [4:0] sel_slot;
		logic [31:0] rdata;
	} drm_state_t;

	drm_state_t st_r;
	drm_state_t st_nxt;

	// Position 1..48 within the current integrator section.
	function automatic logic [5:0] pos_of(input logic [4:0] cnt, input logic hf);
		logic [5:0] p;
		p = {1'b0, cnt} - {1'b0, POS_RELOAD} + POS_FIRST;
		return hf ? p + 6'h18 : p;
	endfunction : pos_of

	// Integrator slot 1..22 from the slot counter.
	function automatic logic [4:0] slot_of(input logic [4:0] cnt);
		return cnt - SLOT_RELOAD + SLOT_FIRST;
	endfunction : slot_of

	function automatic logic reg_hit(input logic [7:0] a);
		return a == OFS_CTRL || a == OFS_SLOT || a == OFS_STATUS || a == OFS_READOUT;
	endfunction : reg_hit

	logic [PIN_N-1:0] pins;
	logic tick;
	logic press_one;
	logic press_zero;
	logic [5:0] pos;
	logic [4:0] slot;
	logic boundary;
	logic selected;
	logic computing;
	logic src_bit;
	logic wr_acc;
	logic [31:0] rd_mux;

	assign pins = {zero_button_pin, one_button_pin, ovf_neg_pin, ovf_pos_pin, intg_neg_pin,
		intg_pos_pin, rem_neg_pin, rem_pos_pin, drum_clock_pin};
	assign tick = st_r.s2[PIN_CLK] & ~st_r.s3[PIN_CLK]; // [R23]
	assign press_one = st_r.s2[PIN_ONE] & ~st_r.s3[PIN_ONE];
	assign press_zero = st_r.s2[PIN_ZERO] & ~st_r.s3[PIN_ZERO];
	assign pos = pos_of(st_r.pos_cnt, st_r.half);
	assign slot = slot_of(st_r.slot_cnt);
	assign boundary = pos == POS_LAST && slot == SLOT_LAST;
	assign selected = slot == st_r.sel_slot;
	assign computing = st_r.run_gate && (st_r.mode == MODE_COMPUTE || st_r.mode == MODE_ONE_OP);
	assign src_bit = st_r.ro_src ? st_r.intg_sync : st_r.rem_sync;
	assign wr_acc = psel && penable && pwrite;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			OFS_CTRL: rd_mux = {26'h0, st_r.ro_half, st_r.ro_src, st_r.eref, st_r.mode};
			OFS_SLOT: rd_mux = {27'h0, st_r.sel_slot};
			OFS_STATUS: rd_mux = {16'h0, pos, slot, st_r.fill_value, st_r.adder_window,
				st_r.halt_latch, st_r.run_request, st_r.run_gate};
			OFS_READOUT: rd_mux = {23'h0, st_r.inc_cnt, st_r.oct_sel, st_r.hold};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		// Only the second and third stages are read; the first exists to let metastability settle.
		st_nxt.s1 = pins;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;

		// Head pulses are wider than pclk, so level tracking never misses one.
		if (st_r.s2[PIN_R_POS]) st_nxt.rem_track = 1'b1; // [R10]
		else if (st_r.s2[PIN_R_NEG]) st_nxt.rem_track = 1'b0; // [R10]
		if (st_r.s2[PIN_Y_POS]) st_nxt.intg_track = 1'b1; // [R11]
		else if (st_r.s2[PIN_Y_NEG]) st_nxt.intg_track = 1'b0; // [R11]
		if (st_r.s2[PIN_Z_POS]) st_nxt.ovf_track = 1'b1; // [R11]
		else if (st_r.s2[PIN_Z_NEG]) st_nxt.ovf_track = 1'b0; // [R11]

		// Fill value and run request follow the buttons; a press beats the clear.
		if (press_one) st_nxt.fill_value = 1'b1; // [R15]
		else if (press_zero) st_nxt.fill_value = 1'b0; // [R15]
		if (press_one || press_zero) begin
			st_nxt.run_request = 1'b1; // [R3]
		end else if (tick && st_r.run_gate) begin
			st_nxt.run_request = 1'b0; // [R3]
		end

		st_nxt.load_due = 1'b0;
		if (st_r.load_due) st_nxt.hold = {src_bit, st_r.stage1, st_r.stage2}; // [R7]

		if (tick) begin
			st_nxt.rem_sync = st_r.rem_track; // [R9]
			st_nxt.intg_sync = st_r.intg_track; // [R11]
			st_nxt.intg_drv = st_r.intg_track; // [R12]
			st_nxt.ovf_sync = st_r.ovf_track; // [R11]
			st_nxt.ovf_delay1 = st_r.ovf_sync;
			// While computing the bit carried a revolution is dropped for the new overflow.
			st_nxt.ovf_delay2 = computing ? rem_overflow : st_r.ovf_delay1; // [R19]

			// Record source selects the loop length of the overflow line.
			if (!st_r.run_gate) begin
				st_nxt.ovf_rec = st_r.ovf_delay1; // [R17]
			end else if (computing) begin
				st_nxt.ovf_rec = st_r.ovf_delay2; // [R18] [R19]
			end else if (selected) begin
				unique case (st_r.mode)
					MODE_FILL_Y, MODE_FILL_R, MODE_STEP_RIGHT: st_nxt.ovf_rec = st_r.ovf_sync; // [R16] [R22]
					MODE_STEP_LEFT: st_nxt.ovf_rec = st_r.ovf_delay2; // [R22]
					default: st_nxt.ovf_rec = st_r.ovf_delay1;
				endcase
			end else begin
				st_nxt.ovf_rec = st_r.ovf_delay1; // [R17]
			end
			if (st_r.eref && st_r.run_gate && pos == POS_LAST) st_nxt.ovf_rec = 1'b1;

			// Fill digit goes where the reference pulse coincides in the selected slot.
			st_nxt.wr_bit = st_r.fill_value; // [R15]
			st_nxt.intg_wr = st_r.run_gate && selected && st_r.ovf_delay1 && st_r.mode == MODE_FILL_Y; // [R15]
			st_nxt.rem_wr = st_r.run_gate && selected && st_r.ovf_delay1 && st_r.mode == MODE_FILL_R; // [R15]

			if (st_r.pos_cnt == POS_FULL) begin
				st_nxt.pos_cnt = POS_RELOAD; // [R20]
				st_nxt.half = ~st_r.half; // [R20]
			end else begin
				st_nxt.pos_cnt = st_r.pos_cnt + 5'h01; // [R20]
			end
			if (pos == POS_LAST) begin
				st_nxt.slot_cnt = (st_r.slot_cnt == SLOT_FULL) ? SLOT_RELOAD : st_r.slot_cnt + 5'h01; // [R6]
			end

			if (boundary) begin
				if (st_r.run_gate) begin
					if (st_r.mode != MODE_COMPUTE || st_r.halt_latch) st_nxt.run_gate = 1'b0; // [R1] [R2]
				end else if (st_r.run_request) begin
					st_nxt.run_gate = 1'b1; // [R1] [R3]
				end
				st_nxt.halt_latch = 1'b0; // [R4]
				st_nxt.oct_sel = st_r.oct_sel + 3'h1; // [R5] [R7]
			end else if (slot == SLOT_FIRST && pos == POS_LAST && first_rem_overflow) begin
				st_nxt.halt_latch = 1'b1; // [R4]
			end

			if (pos == POS_WIN_CLOSE) st_nxt.adder_window = 1'b0; // [R13]
			// Opening is confined to P24..P46 so a Y bit at P48 cannot reopen the window.
			else if (pos > POS_WIN_OPEN && pos < POS_WIN_CLOSE && st_r.intg_sync) st_nxt.adder_window = 1'b1; // [R13]

			if (pos == POS_LAST) st_nxt.inc_cnt = 3'h0; // [R21]
			else if (dy_pickup && st_r.inc_cnt != INC_MAX) st_nxt.inc_cnt = st_r.inc_cnt + 3'h1; // [R21]

			st_nxt.stage1 = src_bit; // [R8]
			st_nxt.stage2 = st_r.stage1; // [R8]
			// The digit is complete one pclk after its third bit enters the input stage.
			if (selected && st_r.half == st_r.ro_half
				&& st_r.pos_cnt - POS_RELOAD == {st_r.oct_sel, 1'b0} + {2'b0, st_r.oct_sel} + 5'h03) begin
				st_nxt.load_due = 1'b1; // [R5] [R8]
			end
		end

		if (psel && !penable) st_nxt.rdata = rd_mux;
		if (wr_acc && paddr == OFS_CTRL) begin
			st_nxt.mode = drm_mode_t'(pwdata[CTRL_MODE_LSB+:3]);
			st_nxt.eref = pwdata[CTRL_EREF_BIT];
			st_nxt.ro_src = pwdata[CTRL_SRC_BIT];
			st_nxt.ro_half = pwdata[CTRL_HALF_BIT];
		end
		if (wr_acc && paddr == OFS_SLOT) st_nxt.sel_slot = pwdata[4:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.pos_cnt <= POS_RELOAD;
			st_r.slot_cnt <= SLOT_RELOAD;
			st_r.oct_sel <= OCT_RST;
			st_r.sel_slot <= SEL_SLOT_RST;
			st_r.mode <= MODE_ONE_OP;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Zero-wait slave: read data is captured in the setup cycle.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_hit(paddr);
	assign prdata = st_r.rdata;

	assign ovf_record_bit = st_r.ovf_rec;
	assign intg_record_en = st_r.intg_wr;
	assign rem_record_en = st_r.rem_wr;
	assign fill_record_bit = st_r.wr_bit;
	assign adder_enable = st_r.adder_window; // [R14]
	assign dy_add_request = st_r.adder_window; // [R14]
	assign increment_count = st_r.inc_cnt;
	assign lamp_bank = st_r.oct_sel;
	assign lamp_digit = st_r.hold;
	assign integrand_sync = st_r.intg_sync;
	assign integrand_sync_driver = st_r.intg_drv;
	assign remainder_sync = st_r.rem_sync;

	property p_gate_boundary;
		@(posedge pclk) disable iff (!presetn)
		(st_r.run_gate != $past(st_r.run_gate)) |-> $past(tick && boundary);
	endproperty
	a_gate_boundary: assert property (p_gate_boundary) else $error("run gate moved off the boundary"); // [R1]

	property p_gate_one_rev;
		@(posedge pclk) disable iff (!presetn)
		(tick && boundary && st_r.run_gate && st_r.mode != MODE_COMPUTE) |=> !st_r.run_gate;
	endproperty
	a_gate_one_rev: assert property (p_gate_one_rev) else $error("run gate outlived one revolution"); // [R2]

	property p_req_clear;
		@(posedge pclk) disable iff (!presetn)
		(tick && st_r.run_gate && !press_one && !press_zero) |=> !st_r.run_request;
	endproperty
	a_req_clear: assert property (p_req_clear) else $error("run request not cleared"); // [R3]

	property p_halt_hold;
		@(posedge pclk) disable iff (!presetn)
		(st_r.halt_latch && !(tick && boundary)) |=> st_r.halt_latch;
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("halt dropped early"); // [R4]

	property p_slot_wrap;
		@(posedge pclk) disable iff (!presetn)
		(tick && pos == POS_LAST && st_r.slot_cnt == SLOT_FULL) |=> st_r.slot_cnt == SLOT_RELOAD;
	endproperty
	a_slot_wrap: assert property (p_slot_wrap) else $error("slot counter wrap wrong"); // [R6]

	property p_pos_wrap;
		@(posedge pclk) disable iff (!presetn)
		(tick && st_r.pos_cnt == POS_FULL) |=> (st_r.pos_cnt == POS_RELOAD && st_r.half != $past(st_r.half));
	endproperty
	a_pos_wrap: assert property (p_pos_wrap) else $error("position counter wrap wrong"); // [R20]

	property p_window_close;
		@(posedge pclk) disable iff (!presetn)
		(tick && pos == POS_WIN_CLOSE) |=> !st_r.adder_window ##1 !adder_enable;
	endproperty
	a_window_close: assert property (p_window_close) else $error("adder window open past close"); // [R13]

	property p_resync;
		@(posedge pclk) disable iff (!presetn)
		tick |=> (st_r.rem_sync == $past(st_r.rem_track) && integrand_sync_driver == integrand_sync);
	endproperty
	a_resync: assert property (p_resync) else $error("channel resample mismatch"); // [R9]

	property p_fill_set;
		@(posedge pclk) disable iff (!presetn)
		press_one |=> st_r.fill_value;
	endproperty
	a_fill_set: assert property (p_fill_set) else $error("fill value not set"); // [R15]

	property p_inc_clear;
		@(posedge pclk) disable iff (!presetn)
		(tick && pos == POS_LAST) |=> increment_count == 3'h0;
	endproperty
	a_inc_clear: assert property (p_inc_clear) else $error("increment count not cleared"); // [R21]

endmodule : drm_sequencer
`default_nettype wire

// *** dv/drm_drum_model.sv ***
// Behavioural drum heads: clock channel and three differentiated data channels.
// Assumes pclk at 250 MHz; one drum pulse every eight pclk, counted from reset.
`timescale 1ns/1ps
`default_nettype none
module drm_drum_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] bits,
	output logic drum_clock_pin,
	output logic [2:0] pos_pins,
	output logic [2:0] neg_pins,
	output var int cnt,
	output var int age
);
	logic [2:0] last_r;

	// Data moves half a pulse after the clock edge, so the square wave settles before the next resample.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age <= 0;
			cnt <= 0;
			drum_clock_pin <= 1'h0;
			pos_pins <= 3'h0;
			neg_pins <= 3'h0;
			last_r <= 3'h0;
		end else begin
			age <= (age == 7) ? 0 : age + 1;
			if (age == 7) begin
				cnt <= cnt + 1;
				drum_clock_pin <= 1'h1;
			end
			if (age == 3) begin
				drum_clock_pin <= 1'h0;
				pos_pins <= bits & ~last_r;
				neg_pins <= ~bits & last_r;
				last_r <= bits;
			end
			if (age == 6) begin
				pos_pins <= 3'h0;
				neg_pins <= 3'h0;
			end
		end
	end
endmodule : drm_drum_model
`default_nettype wire

// *** dv/drm_sequencer_tb_top.sv ***
// Self-checking bench of the drum integrator sequencer.
// Assumes the drum model feeds the heads; registers are reached over APB.
`timescale 1ns/1ps
`default_nettype none
module drm_sequencer_tb_top;
	import drm_pkg::*;
	localparam int REV = 1056;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] bits = 3'h0;
	logic one_b = 1'h0;
	logic zero_b = 1'h0;
	logic fro = 1'h0;
	logic rovf = 1'h0;
	logic dy = 1'h0;
	logic [31:0] prdata;
	logic pready, pslverr, dclk, aen, dreq, rsync, isync, idrv;
	logic orec, irec, rrec, fbit;
	logic [2:0] posp, negp, inc, lbank, ldig;
	int cnt, age;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	int seed = 84359;

	always #2 pclk = ~pclk;

	drm_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.drum_clock_pin(dclk), .rem_pos_pin(posp[0]), .rem_neg_pin(negp[0]), .intg_pos_pin(posp[1]),
		.intg_neg_pin(negp[1]), .ovf_pos_pin(posp[2]), .ovf_neg_pin(negp[2]), .one_button_pin(one_b),
		.zero_button_pin(zero_b), .first_rem_overflow(fro), .rem_overflow(rovf), .dy_pickup(dy),
		.ovf_record_bit(orec), .intg_record_en(irec), .rem_record_en(rrec), .fill_record_bit(fbit),
		.adder_enable(aen), .dy_add_request(dreq), .increment_count(inc), .lamp_bank(lbank), .lamp_digit(ldig),
		.integrand_sync(isync), .integrand_sync_driver(idrv), .remainder_sync(rsync));

	drm_drum_model drum (.pclk(pclk), .presetn(presetn), .bits(bits), .drum_clock_pin(dclk),
		.pos_pins(posp), .neg_pins(negp), .cnt(cnt), .age(age));

	task automatic end_of_test();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0, r, e);
		chk(r, exp);
	endtask : rd

	// Returns once pulse n has been taken and its effects have settled.
	task automatic wp(input int n);
		do @(posedge pclk); while (!(cnt == n && age == 6));
	endtask : wp

	function automatic logic [31:0] st(input int k, input logic [4:0] f);
		st = {16'h0, 6'((k % 48) + 1), 5'(((k / 48) % 22) + 1), f};
	endfunction : st

	task automatic sts(input int n, input logic [4:0] f);
		wp(n);
		chk(32'(lbank), 32'((n / REV) % 8));
		rd(OFS_STATUS, st(n, f));
	endtask : sts

	task automatic press(input logic one);
		one_b <= one;
		zero_b <= ~one;
		repeat (5) @(posedge pclk);
		one_b <= 1'h0;
		zero_b <= 1'h0;
	endtask : press

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			end_of_test();
		end
	end

	initial begin
		int k;
		int b;
		logic [31:0] r;
		logic e;
		logic [2:0] v0, v1;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rd(OFS_CTRL, 32'h4);
		rd(OFS_SLOT, 32'h1);
		rd(OFS_READOUT, 32'h0);
		apb(1'h0, 8'h10, 32'h0, r, e);
		chk(r, 32'h0);
		chk(32'(e), 32'h1);
		apb(1'h1, OFS_STATUS, 32'hFFFFFFFF, r, e);
		for (int i = 0; i < 4; i++) begin
			k = $random(seed);
			apb(1'h1, OFS_CTRL, 32'(k), r, e);
			rd(OFS_CTRL, 32'(k) & 32'h3F);
		end
		k = 1 + ({$random(seed)} % 22);
		apb(1'h1, OFS_SLOT, 32'(k), r, e);
		rd(OFS_SLOT, 32'(k));
		apb(1'h1, OFS_CTRL, 32'h4, r, e);
		k = cnt + 2;
		v0 = 3'h0;
		// Each pass ends on the pulse that the next pass starts from, so it is waited for only once.
		wp(k);
		for (int i = 0; i < 24; i++) begin
			v1 = 3'($random(seed));
			bits <= v1;
			rovf <= 1'($random(seed));
			dy <= 1'($random(seed));
			wp(k + 1);
			chk({isync, rsync}, v0[1:0]);
			wp(k + 2);
			chk({isync, rsync}, v1[1:0]);
			chk(orec, v0[2]);
			chk(idrv, isync);
			chk(dreq, aen);
			v0 = v1;
			k = k + 2;
		end
		bits <= 3'h2;
		dy <= 1'h1;
		k = ((cnt / 48) + 2) * 48;
		for (int p = 1; p <= 48; p++) begin
			wp(k + p);
			chk(inc, (p == 48) ? 0 : ((p < 7) ? p : 7));
			chk(dreq, aen);
			if (p < 23 || p == 48) chk(aen, 32'h0);
			if (p > 24 && p < 47) chk(aen, 32'h1);
		end
		bits <= 3'h0;
		dy <= 1'h0;
		press(1'h1);
		k = cnt + 2;
		sts(k, 5'h12);
		b = ((k / REV) + 1) * REV;
		sts(b - 1, 5'h12);
		sts(b, 5'h13);
		sts(b + 1, 5'h11);
		sts(b + REV - 1, 5'h11);
		sts(b + REV, 5'h10);
		apb(1'h1, OFS_CTRL, 32'h5, r, e);
		press(1'h0);
		k = cnt + 2;
		sts(k, 5'h02);
		b = ((k / REV) + 1) * REV;
		sts(b + 1, 5'h01);
		sts(b + REV, 5'h01);
		fro <= 1'h1;
		sts(b + REV + 48, 5'h05);
		sts(b + 2 * REV - 1, 5'h05);
		sts(b + 2 * REV, 5'h00);
		fro <= 1'h0;
		bits <= 3'h6;
		apb(1'h1, OFS_SLOT, 32'h3, r, e);
		apb(1'h1, OFS_CTRL, 32'h18, r, e);
		press(1'h1);
		b = ((cnt / REV) + 1) * REV;
		wp(b + 106);
		chk({ldig, irec, rrec, fbit}, 6'h3D);
		wp(b + 154);
		chk({ldig, irec, rrec, fbit}, 6'h39);
		end_of_test();
	end
endmodule : drm_sequencer_tb_top
`default_nettype wire
